// file: pfc_defs.svh
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

`define PFC_AW 5
`define PFC_A_CTRL 5'h00
`define PFC_A_PER1 5'h01
`define PFC_A_PER2 5'h02
`define PFC_A_STAT 5'h03
`define PFC_A_MASK 5'h04
`define PFC_A_KEY 5'h05
`define PFC_A_FCLR 5'h06
`define PFC_A_SEVT 5'h07
`define PFC_A_FCL0 5'h08
`define PFC_A_DUTY0 5'h0c
`define PFC_A_TRIG0 5'h10
`define PFC_A_LIVE 5'h14

`define PFC_C_TBEN 0
`define PFC_C_CTR 1
`define PFC_C_SYNCEN 2
`define PFC_C_SEVSEL 3
`define PFC_C_TRGEN 4

`define PFC_F_LIMIT_SOURCE_SEL 14:10
`define PFC_F_LIMIT_POLARITY 9
`define PFC_F_CLEN 8
`define PFC_F_FSRC 7:3
`define PFC_F_FPOL 2
`define PFC_F_FMOD 1:0

`define PFC_FCL_RST 16'h00f8
`define PFC_FCL_WMASK 16'h7fff
`define PFC_PER_RST 16'h03e7
`define PFC_KEY1 16'habcd
`define PFC_KEY2 16'h4321
`define PFC_SRC_SAFETY 5'h1f
`define PFC_SRC_FLT 3'h0
`define PFC_SRC_CMP 3'h2
`define PFC_SAFE_H 1'b0
`define PFC_SAFE_L 1'b0
`define PFC_ST_W 7

`endif

// file: pfc_pkg.sv
package pfc_pkg;

   typedef enum logic [1:0] {
      PFC_FM_LATCH = 2'h0,
      PFC_FM_CYCLE = 2'h1,
      PFC_FM_RSVD = 2'h2,
      PFC_FM_OFF = 2'h3
   } pfc_fmode_type;

   typedef enum logic [1:0] {
      PFC_UL_LOCKED = 2'h0,
      PFC_UL_KEY1 = 2'h1,
      PFC_UL_OPEN = 2'h3
   } pfc_unlock_type;

endpackage

// file: pfc_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_timebase #(
   parameter int DW = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic center,
   input wire logic [DW-1:0] period,
   input wire logic sync_pulse,
   output logic [DW-1:0] cnt,
   output logic start
);
   logic [DW-1:0] cnt_r;
   logic down_r;

   // Center mode counts up to the period and back, so the period must be at least two.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         down_r <= 1'b0;
      end else if (!en || sync_pulse) begin
         cnt_r <= '0;
         down_r <= 1'b0;
      end else if (!center) begin
         cnt_r <= (cnt_r >= period) ? '0 : cnt_r + 1'b1;
         down_r <= 1'b0;
      end else if (down_r) begin // R2
         cnt_r <= cnt_r - 1'b1;
         down_r <= (cnt_r > DW'(1));
      end else if (cnt_r >= period) begin
         cnt_r <= cnt_r - 1'b1;
         down_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign cnt = cnt_r;
   assign start = en & (cnt_r == '0);
endmodule
`default_nettype wire

// file: pfc_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defs.svh"
module pfc_gen (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] fcl,
   input wire logic [3:0] flt_in,
   input wire logic [3:0] cmp_in,
   input wire logic safety_in,
   input wire logic pwm_en,
   input wire logic pwm_raw,
   input wire logic fault_clr,
   input wire logic cyc_start,
   output logic high_side_out,
   output logic low_side_out,
   output logic fault_act,
   output logic limit_act
);
   function automatic logic src_pick(input logic [4:0] code, input logic [3:0] f,
                                     input logic [3:0] c, input logic s);
      logic v;
      v = 1'b0;
      if (code == `PFC_SRC_SAFETY)
         v = s;
      else if (code[4:2] == `PFC_SRC_FLT)
         v = f[code[1:0]];
      else if (code[4:2] == `PFC_SRC_CMP)
         v = c[code[1:0]];
      return v;
   endfunction

   logic latch_r;
   logic latch_nxt;
   logic high_r;
   logic low_r;
   pfc_pkg::pfc_fmode_type mode;
   wire flt_lvl = src_pick(fcl[`PFC_F_FSRC], flt_in, cmp_in, safety_in) ^ fcl[`PFC_F_FPOL];
   wire lim_lvl = src_pick(fcl[`PFC_F_LIMIT_SOURCE_SEL], flt_in, cmp_in, safety_in) ^ fcl[`PFC_F_LIMIT_POLARITY]; // R10 R11
   wire safe = latch_r | limit_act;

   assign mode = pfc_pkg::pfc_fmode_type'(fcl[`PFC_F_FMOD]);
   assign limit_act = fcl[`PFC_F_CLEN] & lim_lvl; // R12

   // An active source re-sets the latch in the same cycle as a clear, so a clear never loses it.
   always_comb begin
      case (mode)
         pfc_pkg::PFC_FM_LATCH: latch_nxt = flt_lvl | (latch_r & ~fault_clr); // R15
         pfc_pkg::PFC_FM_CYCLE: latch_nxt = flt_lvl | (latch_r & ~cyc_start);
         default: latch_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_r <= 1'b1; // R7
         high_r <= `PFC_SAFE_H;
         low_r <= `PFC_SAFE_L;
      end else begin
         latch_r <= latch_nxt;
         high_r <= safe ? `PFC_SAFE_H : (pwm_en & pwm_raw); // R4
         low_r <= safe ? `PFC_SAFE_L : (pwm_en & ~pwm_raw); // R1
      end
   end

   assign high_side_out = high_r;
   assign low_side_out = low_r;
   assign fault_act = latch_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_SAFE_OUT: assert property (safe |=> !high_side_out && !low_side_out) // R4
      else $error("outputs left the safe state during a fault or limit");
   AST_LATCH_HOLD: assert property ( // R15
      mode == pfc_pkg::PFC_FM_LATCH && latch_r && !fault_clr |=> latch_r)
      else $error("latched fault released without a clear");
   AST_LIM_OFF: assert property (!fcl[`PFC_F_CLEN] |-> !limit_act) // R12
      else $error("current limit acts while disabled");
   AST_LIM_SAFETY: assert property ( // R11
      fcl[`PFC_F_CLEN] && fcl[`PFC_F_LIMIT_SOURCE_SEL] == `PFC_SRC_SAFETY
      |-> limit_act == (safety_in ^ fcl[`PFC_F_LIMIT_POLARITY]))
      else $error("limit polarity or safety source wrong");
   COV_LATCH_CLEAR: cover property (latch_r && fault_clr && !flt_lvl ##1 !latch_r);
endmodule
`default_nettype wire

// file: pfc_top.sv
// Operation
// (R1) Three generators each drive one high-side and one low-side output, six in all.
// (R2) Edges resolve to one clock in both alignments; center mode counts up then down.
// (R3) One master counter is compared by every generator so all outputs share its timing.
// (R4) An enabled and asserted fault or current limit forces the outputs to the safe state.
// (R5) Each generator triggers the converter at a set count, and a special trigger follows either master.
// (R6) A sync input restarts the time base and a sync output pulses at each period start.
// (R7) Reset holds the outputs safe and leaves the safety fault enabled, latched and set.
// (R8) Software holds the safety pin inactive and clears the latched fault before running.
// (R9) The fault mode field takes writes whatever the level of the safety input.
// (R10) The limit source field picks fault 1-4, comparator 1-4, the safety input, else nothing.
// (R11) The limit polarity bit set makes the chosen source active low.
// (R12) Current limiting acts only while its enable bit is set.
// (R13) Software changes polarity bits only while the time base is stopped.
// (R14) With the lock strap high, control words take a write only after the key sequence.
// (R15) A latched fault holds the outputs safe until the input is gone and software clears it.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defs.svh"
module pfc_top #(
   parameter int NGEN = 3,
   parameter int DW = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`PFC_AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DW-1:0] rdata,
   input wire logic write_lock_cfg,
   input wire logic [3:0] flt_in,
   input wire logic [3:0] cmp_in,
   input wire logic safety_fault_in,
   input wire logic sync_in,
   output logic [NGEN-1:0] high_side_out,
   output logic [NGEN-1:0] low_side_out,
   output logic [NGEN-1:0] adc_trig,
   output logic special_trig,
   output logic sync_out,
   output logic irq
);
   function automatic logic hit_g(input logic [`PFC_AW-1:0] a,
                                  input logic [`PFC_AW-1:0] base, input int g);
      return a == (base + g[`PFC_AW-1:0]);
   endfunction

   logic [DW-1:0] ctrl_r;
   logic [DW-1:0] per1_r;
   logic [DW-1:0] per2_r;
   logic [DW-1:0] sevt_r;
   logic [`PFC_ST_W-1:0] stat_r;
   logic [`PFC_ST_W-1:0] mask_r;
   logic [DW-1:0] rdata_r;
   logic [DW-1:0] fcl_r [NGEN];
   logic [DW-1:0] duty_r [NGEN];
   logic [DW-1:0] trig_r [NGEN];
   logic [DW-1:0] gen_rd [NGEN];
   logic [NGEN-1:0] adc_r;
   logic [NGEN-1:0] fault_d_r;
   logic [NGEN-1:0] lim_d_r;
   logic [NGEN-1:0] wr_fcl;
   logic [NGEN-1:0] wr_duty;
   logic [NGEN-1:0] wr_trig;
   logic [NGEN-1:0] pwm_raw;
   logic [NGEN-1:0] fault_act;
   logic [NGEN-1:0] lim_act;
   logic [NGEN-1:0] fault_clr;
   logic sync_d_r;
   logic special_r;
   logic sync_out_r;
   logic [DW-1:0] cnt1;
   logic [DW-1:0] cnt2;
   logic tb1_start;
   logic tb2_start;
   logic [DW-1:0] rd_mux;
   logic [DW-1:0] gen_or;
   pfc_pkg::pfc_unlock_type ul_r;
   pfc_pkg::pfc_unlock_type ul_nxt;

   wire wr_ctrl = wr & (addr == `PFC_A_CTRL);
   wire wr_per1 = wr & (addr == `PFC_A_PER1);
   wire wr_per2 = wr & (addr == `PFC_A_PER2);
   wire wr_stat = wr & (addr == `PFC_A_STAT);
   wire wr_mask = wr & (addr == `PFC_A_MASK);
   wire wr_key = wr & (addr == `PFC_A_KEY);
   wire wr_fclr = wr & (addr == `PFC_A_FCLR);
   wire wr_sevt = wr & (addr == `PFC_A_SEVT);

   wire tb_en = ctrl_r[`PFC_C_TBEN];
   wire center = ctrl_r[`PFC_C_CTR];
   wire sync_rise = ctrl_r[`PFC_C_SYNCEN] & sync_in & ~sync_d_r;
   wire [DW-1:0] sev_cnt = ctrl_r[`PFC_C_SEVSEL] ? cnt2 : cnt1;
   wire special_nxt = tb_en & (sev_cnt == sevt_r);
   // Only the control words are guarded; duty, trigger and period stay writable while running.
   wire prot_open = ~write_lock_cfg | (ul_r == pfc_pkg::PFC_UL_OPEN);
   wire [`PFC_ST_W-1:0] st_set = {special_nxt, lim_act & ~lim_d_r, fault_act & ~fault_d_r};
   wire [`PFC_ST_W-1:0] st_clr = wr_stat ? wdata[`PFC_ST_W-1:0] : '0;
   wire [DW-1:0] live_w = DW'({ul_r, lim_act, fault_act});

   assign fault_clr = wr_fclr ? wdata[NGEN-1:0] : '0;

   // Key sequence: first key, then second key, opens one write to a control word.
   always_comb begin
      ul_nxt = ul_r;
      case (ul_r)
         pfc_pkg::PFC_UL_LOCKED: begin
            if (wr_key)
               ul_nxt = (wdata == `PFC_KEY1) ? pfc_pkg::PFC_UL_KEY1 : pfc_pkg::PFC_UL_LOCKED;
         end
         pfc_pkg::PFC_UL_KEY1: begin
            if (wr_key)
               ul_nxt = (wdata == `PFC_KEY2) ? pfc_pkg::PFC_UL_OPEN : pfc_pkg::PFC_UL_LOCKED;
         end
         pfc_pkg::PFC_UL_OPEN: begin
            if (wr_key || (|wr_fcl))
               ul_nxt = pfc_pkg::PFC_UL_LOCKED;
         end
         default: ul_nxt = pfc_pkg::PFC_UL_LOCKED;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         ul_r <= pfc_pkg::PFC_UL_LOCKED;
      else
         ul_r <= ul_nxt; // R14
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= '0;
         per1_r <= `PFC_PER_RST;
         per2_r <= `PFC_PER_RST;
         sevt_r <= '0;
         mask_r <= '0;
      end else begin
         if (wr_ctrl)
            ctrl_r <= wdata;
         if (wr_per1)
            per1_r <= wdata;
         if (wr_per2)
            per2_r <= wdata;
         if (wr_sevt)
            sevt_r <= wdata;
         if (wr_mask)
            mask_r <= wdata[`PFC_ST_W-1:0];
      end
   end

   // Hardware sets win over a same-cycle write-one clear.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_r <= '0;
         // The latches leave reset set, so the edge register starts high to avoid a false event.
         fault_d_r <= '1;
         lim_d_r <= '0;
      end else begin
         stat_r <= (stat_r & ~st_clr) | st_set;
         fault_d_r <= fault_act;
         lim_d_r <= lim_act;
      end
   end

   assign irq = |(stat_r & mask_r);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_d_r <= 1'b0;
         special_r <= 1'b0;
         sync_out_r <= 1'b0;
      end else begin
         sync_d_r <= sync_in;
         special_r <= special_nxt; // R5
         sync_out_r <= tb1_start; // R6
      end
   end

   assign special_trig = special_r;
   assign sync_out = sync_out_r;

   pfc_timebase #(
      .DW(DW)
   ) u_tb1 (
      .clk(clk),
      .rst(rst),
      .en(tb_en),
      .center(center),
      .period(per1_r),
      .sync_pulse(sync_rise),
      .cnt(cnt1),
      .start(tb1_start)
   );

   pfc_timebase #(
      .DW(DW)
   ) u_tb2 (
      .clk(clk),
      .rst(rst),
      .en(tb_en),
      .center(center),
      .period(per2_r),
      .sync_pulse(sync_rise),
      .cnt(cnt2),
      .start(tb2_start)
   );

   for (genvar g = 0; g < NGEN; g++) begin : g_gen
      assign wr_fcl[g] = wr & hit_g(addr, `PFC_A_FCL0, g);
      assign wr_duty[g] = wr & hit_g(addr, `PFC_A_DUTY0, g);
      assign wr_trig[g] = wr & hit_g(addr, `PFC_A_TRIG0, g);
      assign pwm_raw[g] = cnt1 < duty_r[g]; // R3
      assign gen_rd[g] = hit_g(addr, `PFC_A_FCL0, g) ? fcl_r[g] :
                         hit_g(addr, `PFC_A_DUTY0, g) ? duty_r[g] :
                         hit_g(addr, `PFC_A_TRIG0, g) ? trig_r[g] : '0;

      // The mode field sits in the same word and is never gated by the fault level.
      always_ff @(posedge clk or posedge rst) begin
         if (rst)
            fcl_r[g] <= `PFC_FCL_RST; // R7
         else if (wr_fcl[g] && prot_open)
            fcl_r[g] <= wdata & `PFC_FCL_WMASK; // R14 R9
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            duty_r[g] <= '0;
            trig_r[g] <= '0;
            adc_r[g] <= 1'b0;
         end else begin
            if (wr_duty[g])
               duty_r[g] <= wdata;
            if (wr_trig[g])
               trig_r[g] <= wdata;
            adc_r[g] <= tb_en & ctrl_r[`PFC_C_TRGEN] & (cnt1 == trig_r[g]); // R5
         end
      end

      pfc_gen u_gen (
         .clk(clk),
         .rst(rst),
         .fcl(fcl_r[g]),
         .flt_in(flt_in),
         .cmp_in(cmp_in),
         .safety_in(safety_fault_in),
         .pwm_en(tb_en),
         .pwm_raw(pwm_raw[g]),
         .fault_clr(fault_clr[g]),
         .cyc_start(tb1_start),
         .high_side_out(high_side_out[g]),
         .low_side_out(low_side_out[g]),
         .fault_act(fault_act[g]),
         .limit_act(lim_act[g])
      );
   end

   assign adc_trig = adc_r;

   always_comb begin
      gen_or = '0;
      for (int i = 0; i < NGEN; i++) begin
         gen_or = gen_or | gen_rd[i];
      end
   end

   assign rd_mux = (addr == `PFC_A_CTRL) ? ctrl_r :
                   (addr == `PFC_A_PER1) ? per1_r :
                   (addr == `PFC_A_PER2) ? per2_r :
                   (addr == `PFC_A_STAT) ? DW'(stat_r) :
                   (addr == `PFC_A_MASK) ? DW'(mask_r) :
                   (addr == `PFC_A_SEVT) ? sevt_r :
                   (addr == `PFC_A_LIVE) ? live_w : gen_or;

   // Read data stand in the cycle after each cycle with rd high and are zero otherwise.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rdata_r <= '0;
      else
         rdata_r <= rd ? rd_mux : '0;
   end

   assign rdata = rdata_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_RDATA: assert property (rd |=> rdata == $past(rd_mux) ##1 ($past(rd) || rdata == '0))
      else $error("read data wrong or held too long");
   AST_RST_STATE: assert property ( // R7
      $past(rst) |-> fcl_r[0] == `PFC_FCL_RST && fault_act == '1 && high_side_out == '0)
      else $error("safety fault not latched after reset");
   AST_LOCKED: assert property ( // R14
      write_lock_cfg && ul_r != pfc_pkg::PFC_UL_OPEN && wr_fcl[0] |=> $stable(fcl_r[0]))
      else $error("locked control word took a write");
   AST_FMOD_WR: assert property ( // R9
      wr_fcl[0] && prot_open && safety_fault_in |=> fcl_r[0][1:0] == $past(wdata[1:0]))
      else $error("fault mode write refused while safety input high");
   AST_SYNC_RESTART: assert property ( // R6
      sync_rise && tb_en && !wr_ctrl |=> cnt1 == '0 ##1 sync_out)
      else $error("sync input did not restart the time base");
   AST_SPECIAL: assert property (special_trig |-> $past(tb_en && sev_cnt == sevt_r)) // R5
      else $error("special trigger without a match");
   AST_CTR_STEP: assert property ( // R2
      tb_en && center && !sync_rise && !wr_ctrl && !wr_per1 && cnt1 < per1_r && cnt1 != '0
      |=> (cnt1 == $past(cnt1) + 1'b1) || (cnt1 == $past(cnt1) - 1'b1))
      else $error("center counter stepped by more than one");
   AST_IRQ: assert property ((st_set & mask_r) != '0 |=> irq) // R4
      else $error("fault event did not raise the interrupt");
   AST_STAT_HOLD: assert property ( // R4
      (stat_r & ~st_clr) != '0
      |=> (stat_r & $past(stat_r & ~st_clr)) == $past(stat_r & ~st_clr))
      else $error("status bit dropped without a clear");
   AST_SET_WINS: assert property ( // R4
      st_set != '0 |=> (stat_r & $past(st_set)) == $past(st_set))
      else $error("status event lost to a same-cycle clear");

   // Output checks cover every generator at once, except the converter trigger check, which watches adc_trig[0] only.
   AST_FAULT_SAFE: assert property ( // R4
      fault_act != '0 |=> ((high_side_out | low_side_out) & $past(fault_act)) == '0)
      else $error("faulted generator drove an output");
   AST_LIMIT_SAFE: assert property ( // R12
      lim_act != '0 |=> ((high_side_out | low_side_out) & $past(lim_act)) == '0)
      else $error("limited generator drove an output");
   AST_OFF_QUIET: assert property ( // R1
      !tb_en |=> high_side_out == '0 && low_side_out == '0)
      else $error("outputs active while the time base is stopped");
   AST_ADC_MATCH: assert property ( // R5
      adc_trig[0] |-> $past(tb_en && ctrl_r[`PFC_C_TRGEN] && cnt1 == trig_r[0]))
      else $error("converter trigger without a count match");
   AST_SYNC_OUT: assert property (sync_out |-> $past(tb_en && cnt1 == '0)) // R6
      else $error("sync output without a period start");
   AST_UNLOCK_ONE: assert property ( // R14
      ul_r == pfc_pkg::PFC_UL_OPEN && (|wr_fcl) |=> ul_r == pfc_pkg::PFC_UL_LOCKED)
      else $error("unlock stayed open after a control write");
   AST_NO_SKIP: assert property ( // R14
      ul_r == pfc_pkg::PFC_UL_LOCKED |=> ul_r != pfc_pkg::PFC_UL_OPEN)
      else $error("unlock opened without both keys");

   COV_UNLOCK: cover property (ul_r == pfc_pkg::PFC_UL_KEY1 ##1 ul_r == pfc_pkg::PFC_UL_OPEN);
   COV_CENTER: cover property (tb_en && center && cnt1 == per1_r);
   COV_SPECIAL: cover property (special_trig && ctrl_r[`PFC_C_SEVSEL]);
   COV_LIMIT: cover property (lim_act[0] && !fault_act[0]);
endmodule
`default_nettype wire

// file: pfc_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_stage_model (
   input wire logic clk,
   input wire logic [2:0] high_side_out,
   input wire logic [2:0] low_side_out,
   input wire logic [3:0] fault_cmd,
   input wire logic [3:0] cmp_cmd,
   input wire logic safety_drv,
   input wire logic safety_oe,
   input wire logic pin_pulldown_ctrl,
   output logic [3:0] flt_in,
   output logic [3:0] cmp_in,
   output logic safety_fault_in,
   output int shoot_cnt
);
   logic last_r = 1'b0;
   assign flt_in = fault_cmd;
   assign cmp_in = cmp_cmd;
   // A released pin with no pull-down floats, so it shows the inverse of its last level.
   assign safety_fault_in = safety_oe ? safety_drv : (pin_pulldown_ctrl ? 1'b0 : ~last_r);
   always @(posedge clk) begin
      if (safety_oe) begin
         last_r <= safety_drv;
      end
   end
   // Both switches of one leg on together would short the supply rail.
   initial shoot_cnt = 0;
   always @(posedge clk) begin
      if ((high_side_out & low_side_out) != 3'h0) begin
         shoot_cnt <= shoot_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defs.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top;
   typedef struct {logic [15:0] fcl; logic [3:0] f; logic [3:0] c; logic s; logic e;} pfc_row_type;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, lock = 1'b0, sync_in = 1'b0;
   logic sf_drv = 1'b0, sf_oe = 1'b0, pd_en = 1'b0, irq, sev, so, sf_in;
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000, rdata, v;
   logic [3:0] flt_cmd = 4'h0, cmp_cmd = 4'h0, flt_in, cmp_in;
   logic [2:0] hs, ls, adc;
   int fails = 0, n_tests = 0, shoot, w;
   integer a, b, c, h, l, al;
   pfc_row_type rows [10];
   always #5 clk = ~clk;
   pfc_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .write_lock_cfg(lock), .flt_in(flt_in), .cmp_in(cmp_in),
      .safety_fault_in(sf_in), .sync_in(sync_in), .high_side_out(hs), .low_side_out(ls),
      .adc_trig(adc), .special_trig(sev), .sync_out(so), .irq(irq));
   pfc_stage_model i_stage (.clk(clk), .high_side_out(hs), .low_side_out(ls),
      .fault_cmd(flt_cmd), .cmp_cmd(cmp_cmd), .safety_drv(sf_drv), .safety_oe(sf_oe),
      .pin_pulldown_ctrl(pd_en), .flt_in(flt_in), .cmp_in(cmp_in), .safety_fault_in(sf_in),
      .shoot_cnt(shoot));
   task automatic conclude();
      $display("tests=%0d fails=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wreg(input logic [4:0] ad, input logic [15:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [4:0] ad, output logic [15:0] d);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chkreg(input string n, input logic [4:0] ad, input logic [15:0] e);
      logic [15:0] d;
      rreg(ad, d);
      `CHK(n, e, d)
   endtask
   // Watches 40 cycles, four edge-mode periods of ten or two center-mode periods of twenty, so the counts do not depend on phase.
   task automatic watch(input int g);
      a = 0; b = 0; c = 0; h = 0; l = 0; al = 0;
      repeat (40) begin
         @(negedge clk);
         a += so; b += adc[0]; c += sev; h += hs[g]; l += ls[g];
         al += (hs != {3{hs[0]}}) ? 1 : 0;
      end
   endtask
   task automatic tdone(input string n);
      $display("test %s done", n);
   endtask
   initial begin
      #300000;
      fails++;
      conclude();
   end
   initial begin
      rows = '{'{16'h0123, 4'h1, 4'h0, 1'b0, 1'b1}, '{16'h0d23, 4'h8, 4'h0, 1'b0, 1'b1},
         '{16'h0d23, 4'h1, 4'h0, 1'b0, 1'b0}, '{16'h2123, 4'h0, 4'h1, 1'b0, 1'b1},
         '{16'h2d23, 4'h0, 4'h8, 1'b0, 1'b1}, '{16'h7d23, 4'h0, 4'h0, 1'b1, 1'b1},
         '{16'h1123, 4'hf, 4'hf, 1'b1, 1'b0}, '{16'h0323, 4'h0, 4'h0, 1'b0, 1'b1},
         '{16'h0323, 4'h1, 4'h0, 1'b0, 1'b0}, '{16'h0023, 4'h1, 4'h0, 1'b0, 1'b0}};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      chkreg("fcl0 reset", `PFC_A_FCL0, `PFC_FCL_RST);
      chkreg("fcl2 reset", `PFC_A_FCL0 + 5'h02, `PFC_FCL_RST);
      chkreg("per2 reset", `PFC_A_PER2, `PFC_PER_RST);
      chkreg("unmapped", 5'h1f, 16'h0000);
      rreg(`PFC_A_LIVE, v);
      `CHK("fault latched", 3'h7, v[2:0])
      `CHK("safe outputs", 6'h00, {hs, ls})
      tdone("reset");
      @(posedge clk);
      sf_oe <= 1'b1;
      sf_drv <= 1'b1;
      wreg(`PFC_A_FCL0, 16'h00f9);
      chkreg("mode write", `PFC_A_FCL0, 16'h00f9);
      wreg(`PFC_A_FCL0, 16'hffff);
      chkreg("bit15 zero", `PFC_A_FCL0, 16'h7fff);
      tdone("mode");
      // Polarity fields change only here and in the bit15 write above, both with the time base still stopped.
      foreach (rows[i]) begin
         wreg(`PFC_A_FCL0, rows[i].fcl);
         flt_cmd <= rows[i].f;
         cmp_cmd <= rows[i].c;
         sf_drv <= rows[i].s;
         repeat (3) @(posedge clk);
         rreg(`PFC_A_LIVE, v);
         `CHK("limit live", rows[i].e, v[3])
      end
      tdone("table");
      @(posedge clk);
      flt_cmd <= 4'h0;
      cmp_cmd <= 4'h0;
      sf_oe <= 1'b0;
      pd_en <= 1'b1;
      wreg(`PFC_A_FCL0, 16'h00f8);
      wreg(`PFC_A_FCL0 + 5'h01, 16'h0000);
      wreg(`PFC_A_FCL0 + 5'h02, 16'h0009);
      wreg(`PFC_A_FCLR, 16'h0007);
      wreg(`PFC_A_PER1, 16'h0009);
      for (int g = 0; g < 3; g++) begin
         wreg(`PFC_A_DUTY0 + 5'(g), 16'h0005);
      end
      wreg(`PFC_A_TRIG0, 16'h0003);
      wreg(`PFC_A_SEVT, 16'h0002);
      wreg(`PFC_A_CTRL, 16'h0011);
      repeat (3) @(posedge clk);
      watch(0);
      `CHK("sync pulses", 4, a)
      `CHK("adc pulses", 4, b)
      `CHK("special pulses", 4, c)
      `CHK("high count", 20, h)
      `CHK("low count", 20, l)
      `CHK("aligned", 0, al)
      tdone("run");
      wreg(`PFC_A_MASK, 16'h0002);
      flt_cmd <= 4'h1;
      repeat (3) @(negedge clk);
      `CHK("latched safe", 2'b00, {hs[1], ls[1]})
      `CHK("irq set", 1'b1, irq)
      wreg(`PFC_A_FCLR, 16'h0002);
      flt_cmd <= 4'h0;
      watch(1);
      `CHK("stays safe", 0, h + l)
      wreg(`PFC_A_FCLR, 16'h0002);
      repeat (3) @(posedge clk);
      watch(1);
      `CHK("resumed", 40, h + l)
      wreg(`PFC_A_MASK, 16'h0000);
      @(negedge clk);
      `CHK("irq masked", 1'b0, irq)
      wreg(`PFC_A_MASK, 16'h0002);
      @(negedge clk);
      `CHK("irq unmasked", 1'b1, irq)
      wreg(`PFC_A_STAT, 16'h0002);
      @(negedge clk);
      `CHK("irq cleared", 1'b0, irq)
      tdone("latched");
      @(posedge clk);
      flt_cmd <= 4'h2;
      repeat (3) @(negedge clk);
      `CHK("cycle safe", 2'b00, {hs[2], ls[2]})
      @(posedge clk);
      flt_cmd <= 4'h0;
      repeat (14) @(negedge clk);
      watch(2);
      `CHK("cycle recover", 40, h + l)
      tdone("cycle");
      wreg(`PFC_A_CTRL, 16'h0015);
      w = 0;
      do begin
         @(negedge clk);
         w++;
      end while (so !== 1'b1 && w < 20);
      if (so !== 1'b1) begin
         fails++;
         conclude();
      end
      @(posedge clk);
      sync_in <= 1'b1;
      @(posedge clk);
      sync_in <= 1'b0;
      repeat (2) @(negedge clk);
      `CHK("sync restart", 1'b1, so)
      tdone("sync");
      wreg(`PFC_A_PER1, 16'h000a);
      wreg(`PFC_A_CTRL, 16'h0013);
      repeat (3) @(posedge clk);
      watch(0);
      `CHK("center sync", 2, a)
      `CHK("center adc", 4, b)
      `CHK("center special", 4, c)
      `CHK("center high", 18, h)
      `CHK("center low", 22, l)
      tdone("center");
      @(posedge clk);
      lock <= 1'b1;
      wreg(`PFC_A_FCL0, 16'h0100);
      chkreg("locked gen0", `PFC_A_FCL0, 16'h00f8);
      wreg(`PFC_A_FCL0 + 5'h01, 16'h0100);
      chkreg("locked", `PFC_A_FCL0 + 5'h01, 16'h0000);
      wreg(`PFC_A_KEY, `PFC_KEY1);
      wreg(`PFC_A_KEY, `PFC_KEY2);
      wreg(`PFC_A_FCL0 + 5'h01, 16'h0100);
      chkreg("unlocked", `PFC_A_FCL0 + 5'h01, 16'h0100);
      wreg(`PFC_A_FCL0 + 5'h01, 16'h0200);
      chkreg("relocked", `PFC_A_FCL0 + 5'h01, 16'h0100);
      `CHK("no shoot", 0, shoot)
      tdone("lock");
      conclude();
   end
endmodule
`default_nettype wire
